// ===== logic/srs_pkg.sv
// Constants for the serial register slave: function codes, address map, frame layout, CRC and timing.
// Assumes a byte stream from a receiver on the same clock and a transmitter that accepts bytes on a handshake.
package srs_pkg;

	// ==========================================================
	// Function codes
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_READ_INPUT = 8'h04;
	localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
	localparam logic [7:0] FC_READ_WRITE = 8'h17;

	// ==========================================================
	// Address map, in register words
	localparam logic [15:0] CMD_BASE = 16'h03e8;
	localparam logic [15:0] CMD_WORD_A = 16'h03e9;
	localparam logic [15:0] CMD_WORD_B = 16'h03ea;
	localparam logic [15:0] STAT_BASE = 16'h07d0;
	localparam logic [15:0] STAT_WORD_A = 16'h07d0;
	localparam logic [15:0] STAT_WORD_B = 16'h07d1;
	localparam logic [7:0] SLAVE_ID_DEF = 8'h09;
	localparam int CMD_COUNT_DEF = 3;
	localparam int STAT_COUNT_DEF = 2;
	localparam int MAX_FRAME_DEF = 32;

	// ==========================================================
	// Frame layout, byte positions and fixed lengths
	localparam int POS_ID = 0;
	localparam int POS_FC = 1;
	localparam int POS_ADDR = 2;
	localparam int POS_CNT = 4;
	localparam int POS_BC = 6;
	localparam int POS_WADDR = 6;
	localparam int POS_WCNT = 8;
	localparam int POS_WBC = 10;
	localparam int WR_DATA_POS = 7;
	localparam int RW_DATA_POS = 11;
	localparam int CRC_LEN = 2;
	localparam int MIN_LEN = 4;
	localparam int READ_REQ_LEN = 8;
	localparam int RD_HDR_LEN = 3;
	localparam int WR_REPLY_LEN = 8;

	// ==========================================================
	// CRC: reflected polynomial, all ones start, zero residue over a good frame
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_GOOD = 16'h0000;

	// ==========================================================
	// Timing: silence that ends a frame
	localparam int CLK_PERIOD_NS = 25;
	localparam int GAP_NS = 1750000;
	localparam int GAP_CYCLES = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== logic/srs_crc16.sv
// Byte-wise CRC-16 accumulator used for checking received frames and building replies.
// Assumes clr_i and en_i come from logic on the same clock; clear wins over update.
module srs_crc16
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Control and data
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic [7:0] data_i,
	// Running checksum
	output logic [15:0] crc_o
);

	// ==========================================================
	// One byte step of the reflected CRC
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++)
		begin
			if (c[0])
				c = (c >> 1) ^ srs_pkg::CRC_POLY;
			else
				c = c >> 1;
		end
		return c;
	endfunction

	// Accumulator register
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || clr_i)
			crc_o <= srs_pkg::CRC_INIT;
		else if (en_i)
			crc_o <= crc_step(crc_o, data_i);
	end

endmodule

// ===== logic/srs_gap.sv
// Frame end detector: pulses once when the line has been quiet long enough after a byte.
// Assumes byte_i is a one-cycle strobe per received byte from logic on the same clock.
module srs_gap #(
	parameter int unsigned GAP_CYCLES = srs_pkg::GAP_CYCLES
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Byte strobe in, frame end out
	input wire logic byte_i,
	output logic frame_end_o
);

	localparam int CW = $clog2(GAP_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(GAP_CYCLES - 1);

	logic [CW-1:0] idle_cnt_ff;
	logic open_ff;
	logic gap_hit;

	assign gap_hit = open_ff && !byte_i && (idle_cnt_ff == LAST);

	// Quiet time counter, restarted by every byte
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || byte_i)
			idle_cnt_ff <= '0;
		else if (open_ff && !gap_hit)
			idle_cnt_ff <= idle_cnt_ff + 1'b1;
	end

	// Frame open from first byte until the gap
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			open_ff <= 1'b0;
		else if (byte_i)
			open_ff <= 1'b1;
		else if (gap_hit)
			open_ff <= 1'b0;
	end

	// End pulse
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			frame_end_o <= 1'b0;
		else
			frame_end_o <= gap_hit;
	end

endmodule

// ===== logic/srs_slave.sv
// Serial register slave: decodes request frames, writes command bytes, replies with live status.
// Assumes a receiver delivering one-cycle byte strobes and a transmitter taking bytes on valid/ready,
// both on core_clk_i; status bytes come from logic on the same clock.
//
// Operation
// - Function 03 returns requested status registers
// - Read reply: id, code, byte count, data, CRC
// - Two status words hold gripper state bytes
// - Function 04 behaves as 03, echoing 04
// - Function 16 writes the command registers
// - Write reply echoes address and count only
// - Function 23 writes commands and reads status
// - Combined reply: byte count, status ascending, CRC
// - Status sampled live while reply is sent
// - Every frame ends with a CRC-16
// - Addresses and counts travel high byte first
// - Data bytes keep gripper byte order
// - Command and status spaces at fixed bases
module srs_slave #(
	parameter logic [7:0] SLAVE_ID = srs_pkg::SLAVE_ID_DEF,
	parameter int CMD_COUNT = srs_pkg::CMD_COUNT_DEF,
	parameter int STAT_COUNT = srs_pkg::STAT_COUNT_DEF,
	parameter int MAX_FRAME = srs_pkg::MAX_FRAME_DEF,
	parameter int unsigned GAP_CYCLES = srs_pkg::GAP_CYCLES
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Received bytes
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	// Reply bytes
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// Gripper status bytes, byte k at bits 8k+7:8k
	input wire logic [STAT_COUNT*16-1:0] status_bytes_i,
	// Gripper command bytes, byte k at bits 8k+7:8k
	output logic [CMD_COUNT*16-1:0] cmd_bytes_o,
	output logic cmd_update_o,
	// Discarded frame
	output logic frame_drop_o
);

	localparam int IW = $clog2(MAX_FRAME + 1);
	localparam int CMD_BYTES = CMD_COUNT * 2;
	localparam int STAT_BYTES = STAT_COUNT * 2;

	typedef enum logic [1:0] {SRS_RX, SRS_CHECK, SRS_TX} srs_state_t;

	srs_state_t state_ff;
	logic [7:0] rx_buf_ff [MAX_FRAME];
	logic [IW-1:0] rx_len_ff;
	logic ovf_ff;
	logic [7:0] cmd_ff [CMD_BYTES];
	logic [IW-1:0] tx_idx_ff;
	logic [IW-1:0] tx_len_ff;
	logic tx_read_ff;
	logic [15:0] rd_off_ff;
	logic [7:0] tx_bc_ff;
	logic [15:0] rx_crc;
	logic [15:0] tx_crc;
	logic frame_end;
	logic rx_take;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] rx_at(input logic [15:0] idx);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < MAX_FRAME; i++)
		begin
			if (idx == 16'(i))
				b = rx_buf_ff[i];
		end
		return b;
	endfunction

	// Big-endian word from the frame
	function automatic logic [15:0] rx_word(input int pos);
		return {rx_buf_ff[pos], rx_buf_ff[pos+1]};
	endfunction

	// Address window check in 17-bit arithmetic
	function automatic logic in_range(input logic [15:0] addr, input logic [15:0] cnt,
		input logic [15:0] base, input logic [15:0] n);
		logic [16:0] stop;
		stop = {1'b0, addr} + {1'b0, cnt};
		return (cnt != 16'h0000) && (addr >= base) && (stop <= ({1'b0, base} + {1'b0, n}));
	endfunction

	// ==========================================================
	// Sub-blocks
	srs_gap #(
		.GAP_CYCLES(GAP_CYCLES)
	) u_gap (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.byte_i(rx_valid_i),
		.frame_end_o(frame_end)
	);

	assign rx_take = (state_ff == SRS_RX) && rx_valid_i;

	srs_crc16 u_rx_crc (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.clr_i(state_ff == SRS_CHECK),
		.en_i(rx_take),
		.data_i(rx_data_i),
		.crc_o(rx_crc)
	);

	// ==========================================================
	// Request decode
	logic [15:0] len_x;
	logic [15:0] rd_addr;
	logic [15:0] rd_cnt;
	logic [15:0] wr_addr;
	logic [15:0] wr_cnt;
	logic [15:0] wr_bc;
	logic [15:0] data_pos;
	logic head_ok;
	logic req_ok;
	logic req_read;
	logic req_write;

	// Validate the captured frame and pick out its fields
	always_comb
	begin
		len_x = 16'(rx_len_ff);
		rd_addr = rx_word(srs_pkg::POS_ADDR);
		rd_cnt = rx_word(srs_pkg::POS_CNT);
		wr_addr = rx_word(srs_pkg::POS_ADDR);
		wr_cnt = rx_word(srs_pkg::POS_CNT);
		wr_bc = {8'h00, rx_buf_ff[srs_pkg::POS_BC]};
		data_pos = 16'(srs_pkg::WR_DATA_POS);
		req_ok = 1'b0;
		req_read = 1'b0;
		req_write = 1'b0;
		head_ok = !ovf_ff && (len_x >= 16'(srs_pkg::MIN_LEN)) && (rx_buf_ff[srs_pkg::POS_ID] == SLAVE_ID)
			&& (rx_crc == srs_pkg::CRC_GOOD);
		case (rx_buf_ff[srs_pkg::POS_FC])
			srs_pkg::FC_READ_HOLD, srs_pkg::FC_READ_INPUT:
			begin
				req_read = 1'b1;
				req_ok = (len_x == 16'(srs_pkg::READ_REQ_LEN))
					&& in_range(rd_addr, rd_cnt, srs_pkg::STAT_BASE, 16'(STAT_COUNT));
			end
			srs_pkg::FC_WRITE_MULTI:
			begin
				req_write = 1'b1;
				req_ok = (len_x == 16'(srs_pkg::WR_DATA_POS + srs_pkg::CRC_LEN) + wr_bc)
					&& (wr_bc == {wr_cnt[14:0], 1'b0})
					&& in_range(wr_addr, wr_cnt, srs_pkg::CMD_BASE, 16'(CMD_COUNT));
			end
			srs_pkg::FC_READ_WRITE:
			begin
				req_read = 1'b1;
				req_write = 1'b1;
				wr_addr = rx_word(srs_pkg::POS_WADDR);
				wr_cnt = rx_word(srs_pkg::POS_WCNT);
				wr_bc = {8'h00, rx_buf_ff[srs_pkg::POS_WBC]};
				data_pos = 16'(srs_pkg::RW_DATA_POS);
				req_ok = (len_x == 16'(srs_pkg::RW_DATA_POS + srs_pkg::CRC_LEN) + wr_bc)
					&& (wr_bc == {wr_cnt[14:0], 1'b0})
					&& in_range(rd_addr, rd_cnt, srs_pkg::STAT_BASE, 16'(STAT_COUNT))
					&& in_range(wr_addr, wr_cnt, srs_pkg::CMD_BASE, 16'(CMD_COUNT));
			end
			default:
			begin
				req_ok = 1'b0;
			end
		endcase
	end

	logic accept;
	logic tx_take;
	logic tx_more;

	assign accept = (state_ff == SRS_CHECK) && head_ok && req_ok;
	assign tx_take = (state_ff == SRS_TX) && (!tx_valid_o || tx_ready_i);
	assign tx_more = tx_idx_ff < tx_len_ff;

	// ==========================================================
	// Control state
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			state_ff <= SRS_RX;
		else
			unique case (state_ff)
				SRS_RX: if (frame_end) state_ff <= SRS_CHECK;
				SRS_CHECK: state_ff <= accept ? SRS_TX : SRS_RX;
				SRS_TX: if (tx_take && !tx_more) state_ff <= SRS_RX;
				default: state_ff <= SRS_RX; // Unused code falls back to receive
			endcase
	end

	// Frame capture; bytes outside the receive state are ignored
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || state_ff == SRS_CHECK)
		begin
			rx_len_ff <= '0;
			ovf_ff <= 1'b0;
		end
		else if (rx_take)
		begin
			if (rx_len_ff < IW'(MAX_FRAME))
				rx_len_ff <= rx_len_ff + 1'b1;
			else
				ovf_ff <= 1'b1;
		end
	end

	// Frame buffer
	always_ff @(posedge core_clk_i)
	begin
		for (int i = 0; i < MAX_FRAME; i++)
		begin
			if (rst_i)
				rx_buf_ff[i] <= 8'h00;
			else if (rx_take && rx_len_ff == IW'(i))
				rx_buf_ff[i] <= rx_data_i;
		end
	end

	// Command bytes; frame data order is gripper byte order
	always_ff @(posedge core_clk_i)
	begin
		for (int j = 0; j < CMD_BYTES; j++)
		begin
			if (rst_i)
				cmd_ff[j] <= 8'h00;
			else if (accept && req_write && 16'(j) >= {wr_addr - srs_pkg::CMD_BASE, 1'b0}
				&& 16'(j) < {wr_addr - srs_pkg::CMD_BASE + wr_cnt, 1'b0})
				cmd_ff[j] <= rx_at(data_pos + 16'(j) - {wr_addr[14:0] - srs_pkg::CMD_BASE[14:0], 1'b0});
		end
	end

	// Command update and drop pulses
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			cmd_update_o <= 1'b0;
			frame_drop_o <= 1'b0;
		end
		else
		begin
			cmd_update_o <= accept && req_write;
			frame_drop_o <= (state_ff == SRS_CHECK) && !accept;
		end
	end

	genvar g;
	for (g = 0; g < CMD_BYTES; g++)
	begin : g_cmd
		assign cmd_bytes_o[g*8 +: 8] = cmd_ff[g];
	end

	// ==========================================================
	// Reply set-up
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			tx_len_ff <= '0;
			tx_read_ff <= 1'b0;
			rd_off_ff <= 16'h0000;
			tx_bc_ff <= 8'h00;
		end
		else if (accept)
		begin
			tx_read_ff <= req_read;
			rd_off_ff <= rd_addr - srs_pkg::STAT_BASE;
			tx_bc_ff <= {rd_cnt[6:0], 1'b0};
			if (req_read)
				tx_len_ff <= IW'(srs_pkg::RD_HDR_LEN + srs_pkg::CRC_LEN) + IW'({rd_cnt[IW-2:0], 1'b0});
			else
				tx_len_ff <= IW'(srs_pkg::WR_REPLY_LEN);
		end
	end

	// Next reply byte, declared ahead of the reply checksum that reads it
	logic [7:0] tx_byte;
	logic [15:0] stat_idx;

	srs_crc16 u_tx_crc (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.clr_i(state_ff == SRS_CHECK),
		.en_i(tx_take && tx_more && (tx_idx_ff < tx_len_ff - IW'(srs_pkg::CRC_LEN))),
		.data_i(tx_byte),
		.crc_o(tx_crc)
	);

	// Next reply byte; status bytes are read from the live inputs as they go out
	always_comb
	begin
		stat_idx = {rd_off_ff[14:0], 1'b0} + 16'(tx_idx_ff) - 16'(srs_pkg::RD_HDR_LEN);
		tx_byte = 8'h00;
		if (tx_idx_ff == tx_len_ff - IW'(srs_pkg::CRC_LEN))
			tx_byte = tx_crc[7:0];
		else if (tx_idx_ff == tx_len_ff - 1'b1)
			tx_byte = tx_crc[15:8];
		else if (tx_idx_ff < IW'(srs_pkg::POS_ADDR))
			tx_byte = rx_at(16'(tx_idx_ff));
		else if (!tx_read_ff)
			tx_byte = rx_at(16'(tx_idx_ff));
		else if (tx_idx_ff == IW'(srs_pkg::POS_ADDR))
			tx_byte = tx_bc_ff;
		else
			for (int k = 0; k < STAT_BYTES; k++)
			begin
				if (stat_idx == 16'(k))
					tx_byte = status_bytes_i[k*8 +: 8];
			end
	end

	// Reply byte stream
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || state_ff == SRS_CHECK)
			tx_idx_ff <= '0;
		else if (tx_take && tx_more)
			tx_idx_ff <= tx_idx_ff + 1'b1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h00;
		end
		else if (tx_take)
		begin
			tx_valid_o <= tx_more;
			if (tx_more)
				tx_data_o <= tx_byte;
		end
	end

endmodule

// ===== sim/srs_slave_props.sv
// Checker for the serial register slave: reply framing, hold, command and drop pulses.
// Assumes it is bound to srs_slave and sees only that module's ports.
module srs_slave_props #(
	parameter logic [7:0] SLAVE_ID = srs_pkg::SLAVE_ID_DEF,
	parameter int CMD_COUNT = srs_pkg::CMD_COUNT_DEF,
	parameter int STAT_COUNT = srs_pkg::STAT_COUNT_DEF
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Stream ports
	input wire logic rx_valid_i,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// Command side
	input wire logic [CMD_COUNT*16-1:0] cmd_bytes_o,
	input wire logic cmd_update_o,
	input wire logic frame_drop_o
);
	logic take;
	logic [3:0] idx_ff;
	logic [7:0] fc_ff;

	// ==========================================
	// Helper logic
	assign take = tx_valid_o && tx_ready_i;
	// Count reply bytes taken since the last request byte
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || rx_valid_i)
			idx_ff <= 4'h0;
		else if (take)
			idx_ff <= idx_ff + 4'h1;
	end
	// Remember the echoed function code
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			fc_ff <= 8'h00;
		else if (take && idx_ff == 4'h1)
			fc_ff <= tx_data_o;
	end

	// ==========================================
	// Properties
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_hold;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("reply byte moved before it was taken");
	property p_id;
		take && idx_ff == 4'h0 |-> tx_data_o == SLAVE_ID;
	endproperty
	a_id: assert property (p_id)
		else $error("reply does not start with own id");
	property p_fc;
		take && idx_ff == 4'h1 |-> tx_data_o inside {8'h03, 8'h04, 8'h10, 8'h17};
	endproperty
	a_fc: assert property (p_fc)
		else $error("reply code not a served function");
	property p_bcnt;
		take && idx_ff == 4'h2 && fc_ff != 8'h10 |-> !tx_data_o[0] && tx_data_o != 8'h00
			&& tx_data_o <= 8'(2 * STAT_COUNT);
	endproperty
	a_bcnt: assert property (p_bcnt)
		else $error("read byte count out of range");
	property p_wlen;
		take && fc_ff == 8'h10 |-> idx_ff < 4'h8;
	endproperty
	a_wlen: assert property (p_wlen)
		else $error("write reply longer than eight bytes");
	property p_wbase;
		take && idx_ff == 4'h2 && fc_ff == 8'h10 |-> tx_data_o == 8'h03;
	endproperty
	a_wbase: assert property (p_wbase)
		else $error("write reply address high byte wrong");
	property p_upd;
		cmd_update_o |-> ##[0:2] (tx_valid_o && tx_data_o == SLAVE_ID);
	endproperty
	a_upd: assert property (p_upd)
		else $error("no reply after command write");
	property p_drop;
		frame_drop_o |-> !cmd_update_o && !tx_valid_o [*8];
	endproperty
	a_drop: assert property (p_drop)
		else $error("discarded frame was answered");
	property p_cmd;
		$changed(cmd_bytes_o) && !$past(rst_i) |-> cmd_update_o || $past(cmd_update_o);
	endproperty
	a_cmd: assert property (p_cmd)
		else $error("command bytes changed without update");
endmodule

bind srs_slave srs_slave_props #(
	.SLAVE_ID(SLAVE_ID),
	.CMD_COUNT(CMD_COUNT),
	.STAT_COUNT(STAT_COUNT)
) chk_u (
	.core_clk_i(core_clk_i),
	.rst_i(rst_i),
	.rx_valid_i(rx_valid_i),
	.tx_valid_o(tx_valid_o),
	.tx_data_o(tx_data_o),
	.tx_ready_i(tx_ready_i),
	.cmd_bytes_o(cmd_bytes_o),
	.cmd_update_o(cmd_update_o),
	.frame_drop_o(frame_drop_o)
);

// ===== sim/srs_master.sv
// Model of the bus master: sends request frames with a trailing CRC and takes reply bytes.
// Assumes the slave's byte strobe and reply handshake run on core_clk_i.
module srs_master
(
	// Clock
	input wire logic core_clk_i,
	// Request bytes to the slave
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	// Reply handshake
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] seed = 32'hd75f49da;
	logic [31:0] r;
	logic slow = 1'b0;

	// ==========================================
	// Random source and checksum
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = srs_pkg::CRC_INIT;
		foreach (b[i])
		begin
			c ^= {8'h00, b[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ srs_pkg::CRC_POLY : c >> 1;
		end
		return c;
	endfunction

	// ==========================================
	// Line driving
	// Idle levels at time zero
	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b0;
	end
	// Take reply bytes at once, or stall at random when slow
	always @(posedge core_clk_i)
	begin
		r = xs();
		tx_ready_o <= #1 slow ? r[0] : 1'b1;
	end
	// Send a frame body with its CRC, low byte first; bad flips one CRC bit
	task automatic send(input logic [7:0] b[$], input logic bad);
		logic [15:0] c;
		c = crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		foreach (b[i])
		begin
			@(posedge core_clk_i);
			#1 rx_valid_o = 1'b1;
			rx_data_o = b[i];
			@(posedge core_clk_i);
			#1 rx_valid_o = 1'b0;
			rx_data_o = ~b[i];
		end
	endtask
endmodule

// ===== sim/serial_register_slave_commands_tb_top.sv
// Testbench of the serial register slave: reads, writes, combined and discarded frames.
// Assumes srs_slave, srs_master and the bound checker are compiled alongside.
module serial_register_slave_commands_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, rst_i, rx_valid_i, tx_valid_o, tx_ready_i, cmd_update_o, frame_drop_o;
	logic [7:0] rx_data_i, tx_data_o;
	logic [31:0] status_bytes_i;
	logic [47:0] cmd_bytes_o, cmd_m;
	logic [7:0] exp_q[$];
	int err_total, checks, j;

	// ==========================================
	// Clock, design and master
	initial
	begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	srs_slave #(.GAP_CYCLES(8)) dut_u (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i),
		.tx_valid_o(tx_valid_o),
		.tx_data_o(tx_data_o),
		.tx_ready_i(tx_ready_i),
		.status_bytes_i(status_bytes_i),
		.cmd_bytes_o(cmd_bytes_o),
		.cmd_update_o(cmd_update_o),
		.frame_drop_o(frame_drop_o)
	);
	srs_master m_u (
		.core_clk_i(core_clk_i),
		.rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i),
		.tx_ready_o(tx_ready_i)
	);

	// ==========================================
	// Checking and closing
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string msg);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Compare each taken reply byte with the oldest note
	always @(posedge core_clk_i)
	begin
		if (rst_i === 1'b0 && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(48'h1, 48'h0, "unexpected reply byte");
			else
				chk(tx_data_o, exp_q.pop_front(), "reply byte");
		end
	end

	// ==========================================
	// One request and its expected outcome
	task automatic op(input logic [7:0] id, input logic [7:0] fc, input logic [7:0] ra, input logic [7:0] rn,
		input logic [7:0] wa, input logic [7:0] wn, input logic bad);
		logic [7:0] f[$];
		logic [7:0] e[$];
		logic [47:0] tm;
		logic [31:0] d;
		logic [15:0] c;
		logic drop;
		int i;
		@(posedge core_clk_i);
		#1 status_bytes_i = m_u.xs();
		tm = cmd_m;
		f = {id, fc};
		e = {id, fc};
		if (fc != 8'h10)
		begin
			f = {f, 8'h07, ra, 8'h00, rn};
			e.push_back(rn << 1);
			for (i = 0; i < 2 * rn; i++)
				e.push_back(status_bytes_i[8 * (2 * (ra - 8'hd0) + i) +: 8]);
		end
		if (fc > 8'h04)
		begin
			f = {f, 8'h03, wa, 8'h00, wn, 8'(wn << 1)};
			for (i = 0; i < 2 * wn; i++)
			begin
				d = m_u.xs();
				f.push_back(d[7:0]);
				tm[8 * (2 * (wa - 8'he8) + i) +: 8] = d[7:0];
			end
		end
		if (fc == 8'h10)
			e = {e, 8'h03, wa, 8'h00, wn};
		c = m_u.crc16(e);
		e = {e, c[7:0], c[15:8]};
		drop = id != 8'h09 || bad || (fc != 8'h10 && ra - 8'hd0 + rn > 2) || (fc > 8'h04 && wa - 8'he8 + wn > 3);
		if (!drop)
		begin
			exp_q = {exp_q, e};
			cmd_m = tm;
		end
		m_u.send(f, bad);
		if (drop || fc > 8'h04)
		begin
			for (i = 0; i < 40; i++)
			begin
				@(posedge core_clk_i);
				#2;
				if ((drop ? frame_drop_o : cmd_update_o) === 1'b1)
					break;
			end
			if (i == 40)
			begin
				chk(48'h1, 48'h0, "pulse timeout");
				final_report();
			end
		end
		for (i = 0; i < 400 && exp_q.size() > 0; i++)
			@(posedge core_clk_i);
		if (exp_q.size() > 0)
		begin
			chk(48'h1, 48'h0, "reply timeout");
			final_report();
		end
		chk(cmd_bytes_o, cmd_m, "command bytes");
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		err_total = 0;
		checks = 0;
		rst_i = 1'b1;
		status_bytes_i = 32'h0;
		cmd_m = 48'h0;
		repeat (3) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		chk(cmd_bytes_o, 48'h0, "reset command bytes");
		chk(m_u.crc16({8'h09, 8'h03, 8'h07, 8'hd0, 8'h00, 8'h02}), 16'hcec5, "crc");
		// Both read codes, both start words, with and without stalls
		for (j = 0; j < 8; j++)
		begin
			m_u.slow = j[2];
			op(8'h09, j[0] ? 8'h04 : 8'h03, j[1] ? 8'hd1 : 8'hd0, j[1] ? 8'h01 : 8'h02, 8'h00, 8'h00, 1'b0);
		end
		m_u.slow = 1'b1;
		op(8'h09, 8'h10, 8'h00, 8'h00, 8'he8, 8'h03, 1'b0);
		op(8'h09, 8'h10, 8'h00, 8'h00, 8'he9, 8'h02, 1'b0);
		op(8'h09, 8'h17, 8'hd0, 8'h02, 8'he9, 8'h02, 1'b0);
		op(8'h09, 8'h17, 8'hd1, 8'h01, 8'hea, 8'h01, 1'b0);
		// Frames that must be discarded without reply, then one good read
		op(8'h0a, 8'h03, 8'hd0, 8'h02, 8'h00, 8'h00, 1'b0);
		op(8'h0a, 8'h10, 8'h00, 8'h00, 8'he8, 8'h03, 1'b0);
		op(8'h09, 8'h04, 8'hd0, 8'h02, 8'h00, 8'h00, 1'b1);
		op(8'h09, 8'h17, 8'hd0, 8'h02, 8'he9, 8'h02, 1'b1);
		op(8'h09, 8'h03, 8'hd1, 8'h02, 8'h00, 8'h00, 1'b0);
		op(8'h09, 8'h10, 8'h00, 8'h00, 8'he9, 8'h03, 1'b0);
		op(8'h09, 8'h03, 8'hd0, 8'h02, 8'h00, 8'h00, 1'b0);
		repeat (20) @(posedge core_clk_i);
		final_report();
	end
endmodule
